// File: rtl/pump_stage_pkg.sv
/*
  Shared constants for the float pump staging controller: register map,
  field positions, reset values, float input order and timing counts.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package pump_stage_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int FLOATS = 6;
  localparam int PUMPS = 3;
  localparam int SPACE_W = 24;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] SPACE_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;

  // Control register fields and reset value (pump down, simplex, both floats on).
  localparam int CTRL_W = 5;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_COUNT_LSB = 1;
  localparam int CTRL_LOW_EN_BIT = 3;
  localparam int CTRL_HIGH_EN_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h1a;

  // Status register fields.
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_ALARM_BIT = 3;
  localparam int STAT_CTL_LSB = 4;
  localparam int STAT_FLOAT_LSB = 8;

  // Order of the float inputs inside the synchronised vector.
  localparam int FL_LOW = 0;
  localparam int FL_OFF = 1;
  localparam int FL_LEAD = 2;
  localparam int FL_LAG = 3;
  localparam int FL_THIRD = 4;
  localparam int FL_HIGH = 5;

  ////////////////////////////////////////////////////////////////////////
  // Timing: default spacing between staggered pump starts.
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAGGER_TIME_MS = 5;
  localparam int STAGGER_CYCLES = STAGGER_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pump control state.
  typedef enum logic [1:0] {CTL_NORMAL, CTL_ALL_ON, CTL_ALL_OFF} ctl_t;

endpackage

// File: rtl/float_sync.sv
/*
  Two-flop synchroniser for the float contact pins.
  Assumes the pins are asynchronous level signals from the well.
*/
`timescale 1ns/10ps
module float_sync #(
  parameter int WIDTH = pump_stage_pkg::FLOATS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  import pump_stage_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  ////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second stage.
  always_comb
  begin
    s_next.first = pinIn;
    s_next.second = s_reg.first;
  end

  // State register.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign pinSync = s_reg.second;

endmodule // float_sync

// File: rtl/start_spacer.sv
/*
  Pump start spacer: turns pumps off at once but starts them one at a
  time, lowest index first, with a programmable gap between starts.
  Assumes the demand vector comes from logic on the same clock.
*/
`timescale 1ns/10ps
module start_spacer #(
  parameter int PUMPS = pump_stage_pkg::PUMPS,
  parameter int SPACE_W = pump_stage_pkg::SPACE_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [PUMPS-1:0] want,
  input wire logic [SPACE_W-1:0] spacing,
  output logic [PUMPS-1:0] run
);
  import pump_stage_pkg::*;

  typedef struct packed {
    logic [PUMPS-1:0] run;
    logic [SPACE_W-1:0] holdOff;
  } space_t;

  space_t s_reg;
  space_t s_next;
  logic found;
  logic started;

  ////////////////////////////////////////////////////////////////////////
  // Stops are immediate; one new start per expired gap.
  always_comb
  begin
    s_next = s_reg;
    found = 1'b0;
    s_next.run = s_reg.run & want;
    if (s_reg.holdOff != '0)
      s_next.holdOff = s_reg.holdOff - 1'b1;
    else
    begin
      for (int i = 0; i < PUMPS; i++)
      begin
        if (!found && want[i] && !s_reg.run[i])
        begin
          found = 1'b1;
          s_next.run[i] = 1'b1;
          s_next.holdOff = spacing;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign run = s_reg.run;
  assign started = |(s_next.run & ~s_reg.run);

  ////////////////////////////////////////////////////////////////////////
  // With a gap of two or more, no start follows another within two cycles.
  sequence startSeen;
    started && (spacing >= 24'h00_0002);
  endsequence

  AST_START_GAP: assert property (@(posedge clk_sys) disable iff (reset)
    startSeen |=> !started ##1 !started)
    else $error("Pump starts closer than the programmed gap.");

endmodule // start_spacer

// File: rtl/float_pump_staging_control.sv
/*
  Float pump staging controller with an AXI4-Lite register slave.
  Drives up to three pumps from six float contacts, in pump down or
  pump up mode, with backup low and high float alarms.
  Assumes float pins are asynchronous and the bus master is on clk_sys.
*/
`timescale 1ns/10ps
module float_pump_staging_control #(
  parameter logic [pump_stage_pkg::SPACE_W-1:0] STAGGER_RESET =
    pump_stage_pkg::SPACE_W'(pump_stage_pkg::STAGGER_CYCLES)
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic lowFloat,
  input wire logic offFloat,
  input wire logic leadFloat,
  input wire logic lagFloat,
  input wire logic thirdPumpLevel,
  input wire logic highFloat,
  output logic [pump_stage_pkg::PUMPS-1:0] pumpRun,
  output logic alarmOut,
  input wire logic [pump_stage_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pump_stage_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pump_stage_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [pump_stage_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import pump_stage_pkg::*;

  typedef struct packed {
    logic awHave;
    logic [ADDR_W-1:0] awAddr;
    logic wHave;
    logic [DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
    logic [CTRL_W-1:0] ctrl;
    logic [SPACE_W-1:0] spacing;
    ctl_t ctl;
    logic [PUMPS-1:0] want;
    logic alarm;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [FLOATS-1:0] floats;
  logic [PUMPS-1:0] mask;
  logic [PUMPS-1:0] levels;
  logic [1:0] pumpCount;
  logic modeUp;
  logic lowTrip;
  logic highTrip;
  logic offActive;
  logic [DATA_W-1:0] statusWord;

  ////////////////////////////////////////////////////////////////////////
  // Float pins cross into the clock domain before any decision.
  float_sync #(
    .WIDTH(FLOATS)
  ) floatSyncInst (
    .clk_sys(clk_sys),
    .reset(reset),
    .pinIn({highFloat, thirdPumpLevel, lagFloat, leadFloat, offFloat, lowFloat}),
    .pinSync(floats)
  );

  // Pumps start one gap apart and stop immediately.
  start_spacer #(
    .PUMPS(PUMPS),
    .SPACE_W(SPACE_W)
  ) spacerInst (
    .clk_sys(clk_sys),
    .reset(reset),
    .want(s_reg.want),
    .spacing(s_reg.spacing),
    .run(pumpRun)
  );

  ////////////////////////////////////////////////////////////////////////
  // Configuration decode: mode, station size and backup float trips.
  always_comb
  begin
    modeUp = s_reg.ctrl[CTRL_MODE_BIT];
    pumpCount = s_reg.ctrl[CTRL_COUNT_LSB +: 2];
    for (int i = 0; i < PUMPS; i++)
      mask[i] = (i == 0) || (i < int'(pumpCount));
    lowTrip = s_reg.ctrl[CTRL_LOW_EN_BIT] && !floats[FL_LOW];
    highTrip = s_reg.ctrl[CTRL_HIGH_EN_BIT] && floats[FL_HIGH];
    levels = {floats[FL_THIRD], floats[FL_LAG], floats[FL_LEAD]};
    offActive = modeUp ? floats[FL_OFF] : !floats[FL_OFF];
  end

  // Status word seen by software.
  always_comb
  begin
    statusWord = '0;
    statusWord[STAT_RUN_LSB +: PUMPS] = pumpRun;
    statusWord[STAT_ALARM_BIT] = s_reg.alarm;
    statusWord[STAT_CTL_LSB +: 2] = s_reg.ctl;
    statusWord[STAT_FLOAT_LSB +: FLOATS] = floats;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state: pump control first, then the register bus.
  always_comb
  begin
    s_next = s_reg;

    // Backup floats are judged before any staging level.
    if (!modeUp)
    begin
      if (lowTrip)
        s_next.ctl = CTL_ALL_OFF;
      else if (highTrip)
        s_next.ctl = CTL_ALL_ON;
      else
        s_next.ctl = CTL_NORMAL;
    end
    else
    begin
      if (highTrip)
        s_next.ctl = CTL_ALL_OFF;
      else if (lowTrip)
        s_next.ctl = CTL_ALL_ON;
      else
        s_next.ctl = CTL_NORMAL;
    end

    // Pump demand for the chosen control state.
    case (s_next.ctl)
      CTL_ALL_OFF:
      begin
        s_next.want = '0;
        s_next.alarm = 1'b1;
      end
      CTL_ALL_ON:
      begin
        s_next.want = mask;
        s_next.alarm = 1'b1;
      end
      CTL_NORMAL:
      begin
        s_next.alarm = 1'b0;
        if (offActive)
          s_next.want = '0;
        else if (!modeUp)
          s_next.want = (s_reg.want | levels) & mask;
        else
          s_next.want = (s_reg.want | ~levels) & mask;
      end
      default:
      begin
        s_next.want = '0;
        s_next.alarm = 1'b1;
      end
    endcase

    // Write address and data are taken in either order.
    if (awvalid && s_reg.awReady)
    begin
      s_next.awHave = 1'b1;
      s_next.awAddr = awaddr;
    end
    if (wvalid && s_reg.wReady)
    begin
      s_next.wHave = 1'b1;
      s_next.wData = wdata;
      s_next.wStrb = wstrb;
    end
    if (s_reg.bValid && bready)
      s_next.bValid = 1'b0;

    // Commit once both halves are held and no response is pending.
    if (s_next.awHave && s_next.wHave && !s_reg.bValid)
    begin
      s_next.awHave = 1'b0;
      s_next.wHave = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp = RESP_OKAY;
      case (s_next.awAddr)
        CTRL_ADDR:
        begin
          if (s_next.wStrb[0])
            s_next.ctrl = s_next.wData[CTRL_W-1:0];
        end
        SPACE_ADDR:
        begin
          for (int b = 0; b < SPACE_W / 8; b++)
            if (s_next.wStrb[b])
              s_next.spacing[8*b +: 8] = s_next.wData[8*b +: 8];
        end
        STATUS_ADDR:
          s_next.bResp = RESP_OKAY;
        default:
          s_next.bResp = RESP_SLVERR;
      endcase
    end
    s_next.awReady = !s_next.awHave && !s_next.bValid;
    s_next.wReady = !s_next.wHave && !s_next.bValid;

    // Read channel: one outstanding read.
    if (s_reg.rValid && rready)
      s_next.rValid = 1'b0;
    if (arvalid && s_reg.arReady)
    begin
      s_next.rValid = 1'b1;
      s_next.rResp = RESP_OKAY;
      case (araddr)
        CTRL_ADDR:
          s_next.rData = {{(DATA_W - CTRL_W){1'b0}}, s_reg.ctrl};
        SPACE_ADDR:
          s_next.rData = {{(DATA_W - SPACE_W){1'b0}}, s_reg.spacing};
        STATUS_ADDR:
          s_next.rData = statusWord;
        default:
        begin
          s_next.rData = '0;
          s_next.rResp = RESP_SLVERR;
        end
      endcase
    end
    s_next.arReady = !s_next.rValid;
  end

  // State register with defined reset values.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.spacing <= STAGGER_RESET;
      s_reg.ctl <= CTL_NORMAL;
      s_reg.awReady <= 1'b1;
      s_reg.wReady <= 1'b1;
      s_reg.arReady <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign alarmOut = s_reg.alarm;
  assign awready = s_reg.awReady;
  assign wready = s_reg.wReady;
  assign bvalid = s_reg.bValid;
  assign bresp = s_reg.bResp;
  assign arready = s_reg.arReady;
  assign rvalid = s_reg.rValid;
  assign rdata = s_reg.rData;
  assign rresp = s_reg.rResp;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the control decisions.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_LOW_INHIBIT: assert property (
    (!modeUp && lowTrip) |=> (s_reg.want == '0) && s_reg.alarm && (s_reg.ctl == CTL_ALL_OFF))
    else $error("Lost low float did not stop pumps with alarm.");

  AST_DOWN_HIGH: assert property (
    (!modeUp && !lowTrip && highTrip) |=> (s_reg.want == $past(mask)) && alarmOut)
    else $error("High float in pump down did not call all pumps.");

  AST_UP_HIGH: assert property (
    (modeUp && highTrip) |=> (s_reg.want == '0) && alarmOut)
    else $error("High float in pump up did not stop pumps.");

  AST_UP_LOW: assert property (
    (modeUp && !highTrip && lowTrip) |=> (s_reg.want == $past(mask)) && alarmOut)
    else $error("Low float in pump up did not call all pumps.");

  AST_DOWN_OFF: assert property (
    (!modeUp && !lowTrip && !highTrip && !floats[FL_OFF]) |=> (s_reg.want == '0) && !alarmOut)
    else $error("Pumps kept running below the off level.");

  AST_DOWN_LEAD: assert property (
    (!modeUp && !lowTrip && !highTrip && floats[FL_OFF] && floats[FL_LEAD]) |=> s_reg.want[0])
    else $error("Lead pump not called above the lead level.");

  AST_UP_OFF: assert property (
    (modeUp && !lowTrip && !highTrip && floats[FL_OFF]) |=> (s_reg.want == '0))
    else $error("Pumps kept running above the off level in pump up.");

  AST_HOLD_ON: assert property (
    (!modeUp && !lowTrip && !highTrip && floats[FL_OFF] && s_reg.want[0]) |=> s_reg.want[0])
    else $error("Lead pump dropped before the off level.");

  AST_STATION_MASK: assert property (
    1'b1 |=> ((s_reg.want & ~$past(mask)) == '0))
    else $error("Pump demanded beyond the station size.");

  AST_RUN_FOLLOWS: assert property (
    (s_reg.ctl == CTL_ALL_OFF) |=> (pumpRun == '0))
    else $error("Pump still running during a stop override.");

endmodule // float_pump_staging_control

// File: tb/float_string_model.sv
/*
  Well-side partner model: six float switches hung on one level scale.
  Assumes the bench gives a level from 0 to 6; an absent low float reads open.
*/
`timescale 1ns/10ps
module float_string_model (
  input wire logic [2:0] level,
  input wire logic fillMode,
  input wire logic lowFitted,
  output logic lowFloat,
  output logic offFloat,
  output logic leadFloat,
  output logic lagFloat,
  output logic thirdPumpLevel,
  output logic highFloat
);
  ////////////////////////////////////////////////////////////////////////
  // Each float closes once the level reaches its height; a tank hangs the staging floats in reverse order.
  always_comb
  begin
    lowFloat = lowFitted && (level >= 3'h1);
    thirdPumpLevel = level >= (fillMode ? 3'h2 : 3'h5);
    lagFloat = level >= (fillMode ? 3'h3 : 3'h4);
    leadFloat = level >= (fillMode ? 3'h4 : 3'h3);
    offFloat = level >= (fillMode ? 3'h5 : 3'h2);
    highFloat = level >= 3'h6;
  end
endmodule // float_string_model

// File: tb/tb_top.sv
/*
  Self-checking bench for the float pump staging controller.
  Assumes the well model above and a short stagger gap of four cycles.
*/
`timescale 1ns/10ps
`define CHK(a, e, m) begin checksDone++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module tb_top;
  import pump_stage_pkg::*;
  typedef struct packed {logic fit; logic [4:0] ctrl; logic [2:0] lvl; logic [2:0] run; logic alm;} row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [2:0] level = 3'h1;
  logic fillMode = 1'b0;
  logic lowFitted = 1'b1;
  logic lowFloat, offFloat, leadFloat, lagFloat, thirdPumpLevel, highFloat, alarmOut;
  logic [2:0] pumpRun;
  logic [3:0] awaddr = '0;
  logic [3:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  int mismatches = 0;
  int checksDone = 0;
  int cycleCount = 0;
  int t[3] = '{-1, -1, -1};
  // Staging sequence: configuration, level, then the pumps and alarm expected once settled.
  row_t rows[29] = '{
    '{1'h1, 5'h1e, 3'h1, 3'h0, 1'h0}, '{1'h1, 5'h1e, 3'h3, 3'h1, 1'h0},
    '{1'h1, 5'h1e, 3'h2, 3'h1, 1'h0}, '{1'h1, 5'h1e, 3'h4, 3'h3, 1'h0},
    '{1'h1, 5'h1e, 3'h5, 3'h7, 1'h0}, '{1'h1, 5'h1e, 3'h1, 3'h0, 1'h0},
    '{1'h1, 5'h1e, 3'h6, 3'h7, 1'h1}, '{1'h1, 5'h1e, 3'h2, 3'h7, 1'h0},
    '{1'h1, 5'h1e, 3'h0, 3'h0, 1'h1}, '{1'h1, 5'h1c, 3'h5, 3'h3, 1'h0},
    '{1'h1, 5'h1c, 3'h1, 3'h0, 1'h0}, '{1'h1, 5'h1a, 3'h6, 3'h1, 1'h1},
    '{1'h1, 5'h1a, 3'h1, 3'h0, 1'h0}, '{1'h1, 5'h18, 3'h6, 3'h1, 1'h1},
    '{1'h1, 5'h0e, 3'h6, 3'h7, 1'h0}, '{1'h1, 5'h0e, 3'h1, 3'h0, 1'h0},
    '{1'h0, 5'h16, 3'h3, 3'h1, 1'h0}, '{1'h0, 5'h1e, 3'h3, 3'h0, 1'h1},
    '{1'h1, 5'h1e, 3'h1, 3'h0, 1'h0}, '{1'h1, 5'h1f, 3'h5, 3'h0, 1'h0},
    '{1'h1, 5'h1f, 3'h4, 3'h0, 1'h0}, '{1'h1, 5'h1f, 3'h3, 3'h1, 1'h0},
    '{1'h1, 5'h1f, 3'h2, 3'h3, 1'h0}, '{1'h1, 5'h1f, 3'h1, 3'h7, 1'h0},
    '{1'h1, 5'h1f, 3'h4, 3'h7, 1'h0}, '{1'h1, 5'h1f, 3'h5, 3'h0, 1'h0},
    '{1'h1, 5'h1f, 3'h6, 3'h0, 1'h1}, '{1'h1, 5'h1f, 3'h0, 3'h7, 1'h1},
    '{1'h1, 5'h1f, 3'h5, 3'h0, 1'h0}};

  float_string_model wellModel (.level(level), .fillMode(fillMode), .lowFitted(lowFitted), .lowFloat(lowFloat),
    .offFloat(offFloat), .leadFloat(leadFloat), .lagFloat(lagFloat), .thirdPumpLevel(thirdPumpLevel),
    .highFloat(highFloat));

  float_pump_staging_control #(.STAGGER_RESET(24'h00_0004)) dut (.clk_sys(clk_sys), .reset(reset),
    .lowFloat(lowFloat), .offFloat(offFloat), .leadFloat(leadFloat), .lagFloat(lagFloat),
    .thirdPumpLevel(thirdPumpLevel), .highFloat(highFloat), .pumpRun(pumpRun), .alarmOut(alarmOut),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  ////////////////////////////////////////////////////////////////////////
  // Clock of 10 ns period.
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Prints the verdict and ends the run.
  task finish_test;
    if (mismatches == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk_sys)
  begin
    cycleCount++;
    if (cycleCount == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // One register bus transfer; handshakes are judged at the negedge before the deciding rising edge.
  task automatic busXfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic [1:0] r);
    logic done;
    logic awGo;
    logic wGo;
    logic arGo;
    done = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    while (!done)
    begin
      @(negedge clk_sys);
      awGo = awvalid && awready;
      wGo = wvalid && wready;
      arGo = arvalid && arready;
      done = wr ? (bvalid === 1'b1) : (rvalid === 1'b1);
      r = wr ? bresp : rresp;
      q = rdata;
      @(posedge clk_sys);
      if (awGo) awvalid <= 1'b0;
      if (wGo) wvalid <= 1'b0;
      if (arGo) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values and register edges, staging table, then gap width, start spacing and a mid-run reset.
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    `CHK(pumpRun, 3'h0, "pumps run after reset")
    busXfer(1'b0, CTRL_ADDR, '0, rd, rsp);
    `CHK(rd, 32'h0000_001a, "control reset value")
    busXfer(1'b0, SPACE_ADDR, '0, rd, rsp);
    `CHK(rd, 32'h0000_0004, "gap reset value")
    busXfer(1'b0, 4'hc, '0, rd, rsp);
    `CHK(rsp, RESP_SLVERR, "unmapped read")
    busXfer(1'b1, 4'hc, 32'hffff_ffff, rd, rsp);
    `CHK(rsp, RESP_SLVERR, "unmapped write")
    busXfer(1'b1, STATUS_ADDR, 32'hffff_ffff, rd, rsp);
    `CHK(rsp, RESP_OKAY, "status write")
    for (int i = 0; i < 29; i++)
    begin
      busXfer(1'b1, CTRL_ADDR, 32'(rows[i].ctrl), rd, rsp);
      fillMode <= rows[i].ctrl[0];
      lowFitted <= rows[i].fit;
      level <= rows[i].lvl;
      repeat (24) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK(pumpRun, rows[i].run, "pump outputs")
      `CHK(alarmOut, rows[i].alm, "alarm output")
    end
    busXfer(1'b1, SPACE_ADDR, 32'hffff_ffff, rd, rsp);
    busXfer(1'b0, SPACE_ADDR, '0, rd, rsp);
    `CHK(rd, 32'h00ff_ffff, "gap width")
    busXfer(1'b1, SPACE_ADDR, 32'h0000_0009, rd, rsp);
    busXfer(1'b1, CTRL_ADDR, 32'h0000_001e, rd, rsp);
    fillMode <= 1'b0;
    level <= 3'h1;
    repeat (30) @(posedge clk_sys);
    level <= 3'h6;
    for (int c = 0; c < 60; c++)
    begin
      @(negedge clk_sys);
      for (int b = 0; b < 3; b++)
        if (pumpRun[b] === 1'b1 && t[b] < 0) t[b] = c;
    end
    `CHK(t[0] >= 0 && t[1] - t[0] >= 10 && t[2] - t[1] >= 10, 1'b1, "start spacing")
    busXfer(1'b0, STATUS_ADDR, '0, rd, rsp);
    `CHK(rd, 32'h0000_3f1f, "status word")
    // Reset in mid-run: outputs clear, then the reset station size and gap come back.
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(pumpRun, 3'h0, "pumps run in reset")
    `CHK(alarmOut, 1'b0, "alarm in reset")
    `CHK({awready, wready, arready, bvalid, rvalid}, 5'h1c, "bus not idle in reset")
    @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    `CHK(pumpRun, 3'h0, "pumps run after second reset")
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(pumpRun, 3'h1, "simplex after second reset")
    `CHK(alarmOut, 1'b1, "high alarm after second reset")
    busXfer(1'b0, SPACE_ADDR, '0, rd, rsp);
    `CHK(rd, 32'h0000_0004, "gap after second reset")
    finish_test();
  end
endmodule // tb_top
